/* File: rtl/rmc_pkg.sv */
`default_nettype none
package rmc_pkg;
    // operating modes decoded from pins and the auto/manual bit
    typedef enum logic [1:0] {
        RMC_MODE_SMPTE,
        RMC_MODE_ASI,
        RMC_MODE_THROUGH,
        RMC_MODE_STANDBY
    } rmc_mode_t;

    // register byte offsets (32-bit aligned words)
    localparam logic [7:0] RMC_CTRL_OFF = 8'h00;   // control: auto/manual bit
    localparam logic [7:0] RMC_STAT_OFF = 8'h04;   // status: decoded mode and settings
    localparam logic [7:0] RMC_DETECT_OFF = 8'h08; // detector results in auto mode

    // control field positions
    localparam int RMC_CTRL_AUTO_BIT = 0;           // auto/manual bit position
    localparam logic RMC_CTRL_AUTO_RST = 1'b1;      // auto mode after reset

    // detector field positions
    localparam int RMC_DET_SMPTE_BIT = 0;           // software view of smpte detector

    // status field positions
    localparam int RMC_STAT_MODE_LSB = 0;           // two-bit mode code
    localparam int RMC_STAT_BUS20_BIT = 2;          // 20-bit bus selected
    localparam int RMC_STAT_861_BIT = 3;            // cea-861 timing selected
    localparam int RMC_STAT_PROC_BIT = 4;           // processing enabled
    localparam int RMC_STAT_SERIAL_BIT = 5;         // loop-through driving
    localparam int RMC_STAT_INVALID_BIT = 6;        // smpte+asi both high in manual

    // pin synchroniser depth
    localparam int RMC_SYNC_STAGES = 3;
endpackage : rmc_pkg
`default_nettype wire

/* File: rtl/rmc_receiver_mode_control.sv */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - manual mode: asi pin input selects asi
// - both pins low gives data-through mode
// - auto mode: asi pin driven low, no asi
// - timing select high gives hsync/vsync/de
// - bus width pin: high 20, low 10
// - processing pin high enables video processing
// - processing pin low selects low-latency bypass
// - serial enable low pulls both outputs high
// - serial enable high drives differential pair
// - standby pin stops processing, powers down io
// - standby pulls both serial outputs high
// - auto mode: smpte pin outputs detector result
// - manual smpte pin high selects smpte processing
module rmc_receiver_mode_control (
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // two-way asi select pin
    input wire logic asi_select_pin_i,
    output logic asi_select_pin_o,
    output logic asi_select_pin_oe,
    // two-way smpte-present pin
    input wire logic smpte_present_pin_i,
    output logic smpte_present_pin_o,
    output logic smpte_present_pin_oe,
    // plain control pins
    input wire logic timing_style_select,
    input wire logic bus_width_select,
    input wire logic processing_enable_pin,
    input wire logic serial_output_enable,
    input wire logic standby_pin,
    // smpte detector result from the receive path
    input wire logic smpte_detected,
    // serial data from the reclocker
    input wire logic serial_data_in,
    // decoded settings
    output logic [1:0] mode,
    output logic asi_processing_en,
    output logic smpte_processing_en,
    output logic cea861_timing_en,
    output logic bus_20bit_en,
    output logic video_processing_en,
    output logic low_latency_en,
    output logic digital_io_powerdown,
    output logic serial_loop_output_p,
    output logic serial_loop_output_n
);
    // every control pin comes from the board or from the host controller
    // with no relation to clk, so each passes the same three-flop chain;
    // the two shared mode pins are sampled even while the device drives
    // them, since in auto mode their accepted levels are simply not used
    localparam int NPIN = 7; // number of synchronised pins

    // pin vector indices
    localparam int P_ASI = 0;
    localparam int P_SMPTE = 1;
    localparam int P_TIM = 2;
    localparam int P_BUS = 3;
    localparam int P_PROC = 4;
    localparam int P_SER = 5;
    localparam int P_STBY = 6;

    // elaboration check: the accept rule compares stages two and three,
    // so a chain of any other depth would need a different accept rule
    // and is refused here rather than left to misbehave quietly
    if (rmc_pkg::RMC_SYNC_STAGES != 3) begin : g_sync_depth_check
        $error("synchroniser needs three stages");
    end

    // all state in one struct, registered by a single process
    typedef struct packed {
        // synchroniser chain and accepted pin levels
        logic [NPIN-1:0] s1;            // first sync stage
        logic [NPIN-1:0] s2;            // second sync stage
        logic [NPIN-1:0] s3;            // third sync stage
        logic [NPIN-1:0] pins;          // accepted pin levels
        // host register and apb response
        logic auto_mode;                // auto/manual bit
        logic [31:0] rdata;             // apb read data
        logic ready;                    // apb ready
        logic err;                      // apb error
        // decoded mode and shared pin drive
        rmc_pkg::rmc_mode_t mode;       // decoded mode
        logic invalid;                  // both mode pins high in manual
        logic asi_o;                    // asi pin output level
        logic asi_oe;                   // asi pin enable
        logic smpte_o;                  // smpte pin output level
        logic smpte_oe;                 // smpte pin enable
        logic det;                      // registered detector
        // enables seen by the video path
        logic asi_en;                   // asi extraction running
        logic smpte_en;                 // smpte processing running
        logic tim861;                   // cea-861 timing style
        logic bus20;                    // 20-bit parallel bus
        logic proc_en;                  // full video processing
        logic low_lat;                  // low-latency bypass path
        logic io_pd;                    // digital io powered down
        // serial loop-through stage
        logic ser_p;                    // true serial output
        logic ser_n;                    // complement serial output
        logic ser_on;                   // loop-through driving
    } rmc_state_t;

    // registered state and its next value
    rmc_state_t st_q;                   // current state
    rmc_state_t st_d;                   // next state
    logic [NPIN-1:0] raw_pins;          // asynchronous pin levels

    // gather asynchronous pins, one bit per pin index
    assign raw_pins = {
        standby_pin,                    // P_STBY
        serial_output_enable,           // P_SER
        processing_enable_pin,          // P_PROC
        bus_width_select,               // P_BUS
        timing_style_select,            // P_TIM
        smpte_present_pin_i,            // P_SMPTE
        asi_select_pin_i                // P_ASI
    };

    // next-state logic: every field starts from its held value, so a
    // branch that leaves a field alone keeps it; all outputs leave through
    // st_q, one cycle after the decision that sets them
    always_comb begin
        st_d = st_q;
        // three-flop synchroniser, accept when stages two and three agree;
        // a pulse shorter than one clock never sits in both at once, so it
        // never reaches the mode decode
        st_d.s1 = raw_pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < NPIN; i++) begin
            // stages two and three agree: take the level
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.pins[i] = st_q.s3[i];
            end
        end
        // the detector already runs on clk: one register, no synchroniser
        st_d.det = smpte_detected;

        // apb slave: an access is taken on the first edge that sees psel and
        // penable with ready low; ready then stands for one cycle, so the
        // held access phase is never taken a second time
        st_d.ready = 1'b0;
        st_d.err = 1'b0;
        if (psel && penable && !st_q.ready) begin
            st_d.ready = 1'b1;
            st_d.rdata = 32'h0000_0000;
            if (paddr == rmc_pkg::RMC_CTRL_OFF) begin
                // control word: only the auto/manual bit is stored
                if (pwrite) begin
                    st_d.auto_mode = pwdata[rmc_pkg::RMC_CTRL_AUTO_BIT];
                end
                st_d.rdata[rmc_pkg::RMC_CTRL_AUTO_BIT] = st_q.auto_mode;
            end else if (paddr == rmc_pkg::RMC_STAT_OFF) begin
                // status word: decoded mode and settings, read only
                st_d.err = pwrite; // read only
                st_d.rdata[rmc_pkg::RMC_STAT_MODE_LSB +: 2] = st_q.mode;
                st_d.rdata[rmc_pkg::RMC_STAT_BUS20_BIT] = st_q.bus20;
                st_d.rdata[rmc_pkg::RMC_STAT_861_BIT] = st_q.tim861;
                st_d.rdata[rmc_pkg::RMC_STAT_PROC_BIT] = st_q.proc_en;
                st_d.rdata[rmc_pkg::RMC_STAT_SERIAL_BIT] = st_q.ser_on;
                st_d.rdata[rmc_pkg::RMC_STAT_INVALID_BIT] = st_q.invalid;
            end else if (paddr == rmc_pkg::RMC_DETECT_OFF) begin
                // detector word, read only
                st_d.err = pwrite; // read only
                st_d.rdata[rmc_pkg::RMC_DET_SMPTE_BIT] = st_q.det;
            end else begin
                // unmapped: error, read zero; nothing is written, so a stray
                // write cannot disturb the auto/manual bit
                st_d.err = 1'b1;
            end
        end

        // pin direction follows the auto/manual bit: the shared pins turn
        // round one cycle after it changes; in auto mode the asi pin is a
        // status output held low and the smpte pin reports the detector
        st_d.asi_oe = st_q.auto_mode;
        st_d.asi_o = 1'b0;
        st_d.smpte_oe = st_q.auto_mode;
        st_d.smpte_o = st_q.det;

        // mode decode; standby overrides everything, then the auto/manual
        // bit; in manual mode the smpte pin outranks the asi pin, and the
        // pair of both high is flagged in status rather than refused
        st_d.invalid = 1'b0;
        if (st_q.pins[P_STBY]) begin
            // standby: no processing, digital io down
            st_d.mode = rmc_pkg::RMC_MODE_STANDBY;
        end else if (st_q.auto_mode) begin
            // auto: asi never recognised, detector picks smpte or through
            st_d.mode = st_q.det ? rmc_pkg::RMC_MODE_SMPTE
                                 : rmc_pkg::RMC_MODE_THROUGH;
        end else if (st_q.pins[P_SMPTE]) begin
            // manual: smpte pin high selects smpte processing
            st_d.mode = rmc_pkg::RMC_MODE_SMPTE;
            st_d.invalid = st_q.pins[P_ASI];
        end else if (st_q.pins[P_ASI]) begin
            // manual: asi extraction, host holds smpte low
            st_d.mode = rmc_pkg::RMC_MODE_ASI;
        end else begin
            // manual: both pins low, plain serial to parallel
            st_d.mode = rmc_pkg::RMC_MODE_THROUGH;
        end

        // per-mode enables follow the registered mode one cycle behind it;
        // all come from the one mode field, so two of them are never on
        // together, not even in the cycle of a mode change
        st_d.asi_en = (st_q.mode == rmc_pkg::RMC_MODE_ASI);
        st_d.smpte_en = (st_q.mode == rmc_pkg::RMC_MODE_SMPTE);
        st_d.io_pd = (st_q.mode == rmc_pkg::RMC_MODE_STANDBY);
        st_d.tim861 = st_q.pins[P_TIM];
        st_d.bus20 = st_q.pins[P_BUS];
        // processing only outside standby; in standby neither the full
        // path nor the low-latency bypass runs
        st_d.proc_en = st_q.pins[P_PROC] && !st_q.pins[P_STBY];
        st_d.low_lat = !st_q.pins[P_PROC] && !st_q.pins[P_STBY];

        // serial loop-through: idle high on disable or standby; standby
        // wins over the enable pin, and the data path is gated by the
        // registered enable so the pair never shows a half-enabled cycle
        st_d.ser_on = st_q.pins[P_SER] && !st_q.pins[P_STBY];
        if (st_q.ser_on) begin
            st_d.ser_p = serial_data_in;
            st_d.ser_n = !serial_data_in;
        end else begin
            st_d.ser_p = 1'b1;
            st_d.ser_n = 1'b1;
        end
    end

    // state register; the asynchronous reset loads constants only, field
    // by field, so every reset level can be read off in one place and no
    // field is written twice in one branch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // reset: auto mode, smpte mode, both shared pins driven low,
            // serial outputs idle high
            st_q.s1 <= '0;
            st_q.s2 <= '0;
            st_q.s3 <= '0;
            st_q.pins <= '0;
            st_q.auto_mode <= rmc_pkg::RMC_CTRL_AUTO_RST;
            st_q.rdata <= 32'h0000_0000;
            st_q.ready <= 1'b0;
            st_q.err <= 1'b0;
            st_q.mode <= rmc_pkg::RMC_MODE_SMPTE;
            st_q.invalid <= 1'b0;
            st_q.asi_o <= 1'b0;
            st_q.asi_oe <= rmc_pkg::RMC_CTRL_AUTO_RST;
            st_q.smpte_o <= 1'b0;
            st_q.smpte_oe <= rmc_pkg::RMC_CTRL_AUTO_RST;
            st_q.det <= 1'b0;
            st_q.asi_en <= 1'b0;
            st_q.smpte_en <= 1'b1;
            st_q.tim861 <= 1'b0;
            st_q.bus20 <= 1'b0;
            st_q.proc_en <= 1'b0;
            st_q.low_lat <= 1'b0;
            st_q.io_pd <= 1'b0;
            st_q.ser_p <= 1'b1;
            st_q.ser_n <= 1'b1;
            st_q.ser_on <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops, no logic after the register
    // apb response
    assign prdata = st_q.rdata;
    assign pready = st_q.ready;
    assign pslverr = st_q.err;
    // shared mode pins
    assign asi_select_pin_o = st_q.asi_o;
    assign asi_select_pin_oe = st_q.asi_oe;
    assign smpte_present_pin_o = st_q.smpte_o;
    assign smpte_present_pin_oe = st_q.smpte_oe;
    // decoded settings
    assign mode = st_q.mode;
    assign asi_processing_en = st_q.asi_en;
    assign smpte_processing_en = st_q.smpte_en;
    assign cea861_timing_en = st_q.tim861;
    assign bus_20bit_en = st_q.bus20;
    assign video_processing_en = st_q.proc_en;
    assign low_latency_en = st_q.low_lat;
    assign digital_io_powerdown = st_q.io_pd;
    // serial loop-through pair
    assign serial_loop_output_p = st_q.ser_p;
    assign serial_loop_output_n = st_q.ser_n;
endmodule : rmc_receiver_mode_control

`default_nettype wire

/* File: tb/rmc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host controller side of the two shared mode pins
module rmc_host_model (
    input wire logic dev_oe_a,
    input wire logic dev_o_a,
    input wire logic dev_oe_s,
    input wire logic dev_o_s,
    input wire logic want_a,
    input wire logic want_s,
    input wire logic bad,
    output logic asi_w,
    output logic smpte_w
);
    // host lets go of a pin whenever the device drives it
    assign asi_w = dev_oe_a ? dev_o_a : want_a;
    // smpte held low while asking for asi, unless told to misbehave
    assign smpte_w = dev_oe_s ? dev_o_s : (want_s & (~want_a | bad));
endmodule : rmc_host_model
`default_nettype wire

/* File: tb/rmc_mode_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rmc_mode_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic asi_select_pin_o,
    input wire logic asi_select_pin_oe,
    input wire logic smpte_present_pin_o,
    input wire logic smpte_present_pin_oe,
    input wire logic smpte_detected,
    input wire logic [1:0] mode,
    input wire logic asi_processing_en,
    input wire logic smpte_processing_en,
    input wire logic video_processing_en,
    input wire logic low_latency_en,
    input wire logic digital_io_powerdown,
    input wire logic serial_loop_output_p,
    input wire logic serial_loop_output_n
);
    // one clock domain: shared clocking and reset guard
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    asi_pin_low_a: assert property (asi_select_pin_oe |-> !asi_select_pin_o)
        else $error("asi pin driven high");
    auto_no_asi_a: assert property (asi_select_pin_oe && $past(asi_select_pin_oe, 2)
        |-> mode != 2'h1) else $error("asi mode in auto");
    smpte_out_a: assert property (smpte_present_pin_oe && $past(smpte_present_pin_oe)
        |-> smpte_present_pin_o == $past(smpte_detected, 2)) else $error("smpte pin stale");
    asi_decode_a: assert property (mode == 2'h1 |=> asi_processing_en
        && !smpte_processing_en) else $error("asi enables wrong");
    smpte_decode_a: assert property (mode == 2'h0 |=> smpte_processing_en
        && !asi_processing_en) else $error("smpte enables wrong");
    auto_asi_off_a: assert property (asi_select_pin_oe && $past(asi_select_pin_oe)
        |-> !asi_processing_en) else $error("asi running in auto");
    stby_io_a: assert property (mode == 2'h3 |=> digital_io_powerdown)
        else $error("io not powered down");
    stby_serial_a: assert property (mode == 2'h3 |=> serial_loop_output_p
        && serial_loop_output_n) else $error("serial not high");
    stby_proc_a: assert property (mode == 2'h3 |-> !video_processing_en
        && !low_latency_en) else $error("processing in standby");
    proc_excl_a: assert property (!(video_processing_en && low_latency_en))
        else $error("both paths on");
endmodule : rmc_mode_checker
bind rmc_receiver_mode_control rmc_mode_checker u_chk (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // bus master and pin drive, all valued at time zero
    logic clk, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic timing_style_select = 1'h0, bus_width_select = 1'h0, processing_enable_pin = 1'h0;
    logic serial_output_enable = 1'h0, standby_pin = 1'h0, smpte_detected = 1'h0;
    logic serial_data_in = 1'h0, want_a = 1'h0, want_s = 1'h0, bad = 1'h0;
    // shared pins and decoded outputs
    logic asi_select_pin_i, asi_select_pin_o, asi_select_pin_oe, smpte_present_pin_i;
    logic smpte_present_pin_o, smpte_present_pin_oe, asi_processing_en, smpte_processing_en;
    logic cea861_timing_en, bus_20bit_en, video_processing_en, low_latency_en;
    logic digital_io_powerdown, serial_loop_output_p, serial_loop_output_n;
    logic [1:0] mode;
    int fails = 0, samples_checked = 0, cyc = 0;
    rmc_receiver_mode_control uut (.*);
    rmc_host_model host (.dev_oe_a(asi_select_pin_oe), .dev_o_a(asi_select_pin_o),
        .dev_oe_s(smpte_present_pin_oe), .dev_o_s(smpte_present_pin_o), .want_a(want_a),
        .want_s(want_s), .bad(bad), .asi_w(asi_select_pin_i), .smpte_w(smpte_present_pin_i));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        // wait as long as it takes; only the cycle ceiling ends a hang
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // covers the synchroniser and decode latency
    task automatic wt;
        repeat (8) @(posedge clk);
    endtask : wt
    task automatic t_reset;
        chk({mode, smpte_processing_en, serial_loop_output_p, serial_loop_output_n,
            asi_select_pin_oe, asi_select_pin_o}, 32'h1E);
    endtask : t_reset
    // control default, unmapped read and read-only write
    task automatic t_regs;
        apb(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h1);
        apb(1'h0, 8'h0C, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'h1, 8'h04, 32'h7F);
        chk(er, 32'h1);
    endtask : t_regs
    // auto mode: host asks for asi in vain, smpte pin shows detector
    task automatic t_auto;
        want_a <= 1'h1;
        wt;
        chk({mode, smpte_present_pin_o}, 32'h4);
        smpte_detected <= 1'h1;
        wt;
        chk({mode, smpte_present_pin_o, smpte_present_pin_oe}, 32'h3);
        apb(1'h0, 8'h08, 32'h0);
        chk(rd, 32'h1);
    endtask : t_auto
    // manual mode: every smpte/asi pin pair, invalid pair included
    task automatic t_manual;
        logic [4:0] ex [4] = '{5'h02, 5'h04, 5'h14, 5'h09};
        apb(1'h1, 8'h00, 32'h0);
        for (int i = 0; i < 4; i++) begin
            want_s <= i inside {1, 2};
            want_a <= i inside {2, 3};
            bad <= (i == 2);
            wt;
            apb(1'h0, 8'h04, 32'h0);
            chk({rd[6], asi_processing_en, smpte_processing_en, mode}, ex[i]);
        end
    endtask : t_manual
    task automatic t_pins;
        for (int i = 0; i < 2; i++) begin
            timing_style_select <= i[0];
            bus_width_select <= ~i[0];
            processing_enable_pin <= i[0];
            wt;
            chk({cea861_timing_en, bus_20bit_en, video_processing_en, low_latency_en},
                i ? 32'hA : 32'h5);
        end
    endtask : t_pins
    // loop-through off, then true and complement of both data levels
    task automatic t_serial;
        for (int i = 0; i < 3; i++) begin
            serial_output_enable <= (i != 0);
            serial_data_in <= (i != 2);
            wt;
            chk({serial_loop_output_p, serial_loop_output_n}, 3 - i);
        end
    endtask : t_serial
    // one-cycle pulse ignored; standby then overrides asi mode
    task automatic t_standby;
        standby_pin <= 1'h1;
        @(posedge clk);
        standby_pin <= 1'h0;
        wt;
        chk(mode, 32'h1);
        standby_pin <= 1'h1;
        wt;
        chk({mode, digital_io_powerdown, serial_loop_output_p, serial_loop_output_n,
            video_processing_en, low_latency_en}, 32'h7C);
        apb(1'h0, 8'h04, 32'h0);
        chk(rd, 32'hB);
        standby_pin <= 1'h0;
        apb(1'h1, 8'h00, 32'h1);
        wt;
        chk({mode, asi_select_pin_oe, asi_processing_en}, 32'h2);
    endtask : t_standby
    task automatic give_verdict;
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // cycle ceiling against a hung run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        t_reset;
        sys_rst <= 1'h0;
        t_regs;
        t_auto;
        t_manual;
        t_pins;
        t_serial;
        t_standby;
        give_verdict;
    end
endmodule : tb_top
`default_nettype wire
